// *** bus_range_node_map.sv ***
// routing decoder: four bus range map registers steer configuration cycles
// assumes a synchronous configuration access port and a routing request port
`timescale 1ns/1ps
`default_nettype none
`include "bus_range_map_regs.svh"
module bus_range_node_map
  import bus_range_map_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire bus_range_map_pkg::cfg_addr_t cfg_addr,
  input wire bus_range_map_pkg::word_t cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic route_req,
  input wire logic route_is_write,
  input wire bus_range_map_pkg::number_t bus_number,
  input wire logic [4:0] device_number,
  output logic route_valid,
  output logic route_hit,
  output logic [2:0] dest_node_id,
  output logic [1:0] dest_link_id,
  output logic dest_sublink,
  output logic device_number_compare_enable
);
  import bus_range_map_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // decode used for writes and reads alike
  function automatic logic [2:0] map_index(input cfg_addr_t a);
    if (a == `MAP_OFF_0) map_index = 3'h4;
    else if (a == `MAP_OFF_1) map_index = 3'h5;
    else if (a == `MAP_OFF_2) map_index = 3'h6;
    else if (a == `MAP_OFF_3) map_index = 3'h7;
    else map_index = 3'h0;
  endfunction : map_index

  logic [2:0] wr_dec;
  logic [2:0] rd_dec;
  word_t store_rdata;
  word_t entries [`MAP_ENTRIES];
  logic rd_hit;
  assign wr_dec = map_index(cfg_addr);
  assign rd_dec = map_index(cfg_addr);
  assign rd_hit = cfg_rd && rd_dec[2];

  map_reg_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(cfg_wr && wr_dec[2]),
    .wr_idx(wr_dec[1:0]),
    .wr_data(cfg_wdata),
    .rd_idx(rd_dec[1:0]),
    .rd_en(rd_hit),
    .rd_data(store_rdata),
    .entries(entries)
  );

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  // the store answers in the cycle after the strobe, so valid is delayed to match
  logic rvalid_reg;
  logic rvalid_next;
  always_comb
  begin
    rvalid_next = cfg_rd;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
    end
  end
  // read data is the store's own register; unmapped offsets leave it zero, so no mux
  // sits between the flop and the pin and every node answers with the same word
  assign cfg_rdata = store_rdata;
  assign cfg_rvalid = rvalid_reg;

  // ----------------------------------------
  // range compare
  // ----------------------------------------
  // compare mode is the bit of the first entry, as software checks that one
  logic cmp_dev;
  number_t cmp_num;
  logic [`MAP_ENTRIES-1:0] hit;
  assign cmp_dev = entries[0][`FLD_DEV_CMP];
  assign cmp_num = cmp_dev ? {3'h0, device_number} : bus_number;

  genvar g;
  generate
    for (g = 0; g < `MAP_ENTRIES; g++)
    begin : g_cmp
      logic en;
      assign en = route_is_write ? entries[g][`FLD_WE] : entries[g][`FLD_RE];
      assign hit[g] = en
        && (cmp_num >= entries[g][`FLD_BASE_HI:`FLD_BASE_LO])
        && (cmp_num <= entries[g][`FLD_LIMIT_HI:`FLD_LIMIT_LO]);
    end
  endgenerate

  // ----------------------------------------
  // route result
  // ----------------------------------------
  // lowest matching entry wins when software leaves ranges overlapping
  logic valid_reg, valid_next, hitq_reg, hitq_next, sub_reg, sub_next, cmp_reg, cmp_next;
  node_t node_reg, node_next;
  link_t link_reg, link_next;
  always_comb
  begin
    valid_next = route_req;
    hitq_next = 1'b0;
    node_next = 3'h0;
    link_next = 2'h0;
    sub_next = 1'b0;
    cmp_next = cmp_dev;
    for (int i = `MAP_ENTRIES - 1; i >= 0; i--)
    begin
      if (route_req && hit[i])
      begin
        hitq_next = 1'b1;
        node_next = entries[i][`FLD_NODE_HI:`FLD_NODE_LO];
        link_next = entries[i][`FLD_LINK_HI:`FLD_LINK_LO];
        sub_next = entries[i][`FLD_SUBLINK];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_reg <= 1'b0;
      hitq_reg <= 1'b0;
      node_reg <= 3'h0;
      link_reg <= 2'h0;
      sub_reg <= 1'b0;
      cmp_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= valid_next;
      hitq_reg <= hitq_next;
      node_reg <= node_next;
      link_reg <= link_next;
      sub_reg <= sub_next;
      cmp_reg <= cmp_next;
    end
  end
  assign route_valid = valid_reg;
  assign route_hit = hitq_reg;
  assign dest_node_id = node_reg;
  assign dest_link_id = link_reg;
  assign dest_sublink = sub_reg;
  assign device_number_compare_enable = cmp_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // routing port: one answer per request, exactly one cycle later
  AST_NO_REQ_NO_VALID: assert property (@(posedge clk) disable iff (!rst_n)
    !route_req |=> !route_valid && !route_hit) else $error("route answer without request");
  AST_VALID_FOLLOWS_REQ: assert property (@(posedge clk) disable iff (!rst_n)
    route_req |=> route_valid) else $error("route request not answered");
  AST_MISS_FIELDS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    !route_hit |-> dest_node_id == 3'h0 && dest_link_id == 2'h0 && !dest_sublink)
    else $error("destination fields set on a miss");
  // entry 0 is the lowest index, so a match there wins over any other entry
  AST_HIT_IN_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    route_req && !cmp_dev && entries[0][`FLD_RE] && !route_is_write
    && bus_number >= entries[0][23:16] && bus_number <= entries[0][31:24]
    |=> route_hit && dest_node_id == $past(entries[0][6:4])) else $error("entry 0 read miss");
  AST_ENTRY0_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
    route_req && !cmp_dev && entries[0][`FLD_RE] && !route_is_write
    && bus_number >= entries[0][23:16] && bus_number <= entries[0][31:24]
    |=> dest_link_id == $past(entries[0][9:8]) && dest_sublink == $past(entries[0][10]))
    else $error("entry 0 link fields wrong");
  AST_BELOW_BASE_MISS: assert property (@(posedge clk) disable iff (!rst_n)
    route_req && (hit == 4'h0) |=> !route_hit) else $error("hit with no matching entry");
  AST_DEV_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    route_req && cmp_dev && entries[0][`FLD_RE] && !route_is_write
    && {3'h0, device_number} >= entries[0][23:16]
    && {3'h0, device_number} <= entries[0][31:24]
    |=> route_hit && dest_node_id == $past(entries[0][6:4]))
    else $error("device compare not used");
  // gating: an entry without the enable for the cycle's direction never routes it
  AST_WE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    route_req && route_is_write && !entries[0][1] && !entries[1][1] && !entries[2][1]
    && !entries[3][1] |=> !route_hit) else $error("write routed without enable");
  AST_RE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    route_req && !route_is_write && !entries[0][0] && !entries[1][0] && !entries[2][0]
    && !entries[3][0] |=> !route_hit) else $error("read routed without enable");
  // register port: one answer per read, reserved and unmapped bits read zero
  AST_RVALID_FOLLOWS_RD: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd |=> cfg_rvalid) else $error("read not answered");
  AST_RVALID_ONLY_AFTER_RD: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_rd |=> !cfg_rvalid) else $error("read answer without read");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rvalid |-> (cfg_rdata & ~`MAP_RW_MASK) == 32'h0) else $error("reserved bits set");
  AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd && !rd_dec[2] |=> cfg_rvalid && cfg_rdata == 32'h0) else $error("unmapped nonzero");
  AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == `MAP_OFF_0 |=> entries[0] == ($past(cfg_wdata) & `MAP_RW_MASK))
    else $error("write to first entry lost");
  AST_UNMAPPED_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && !wr_dec[2] |=> entries[0] == $past(entries[0])
    && entries[1] == $past(entries[1]) && entries[2] == $past(entries[2])
    && entries[3] == $past(entries[3])) else $error("unmapped write changed an entry");
  // a write, one quiet cycle, then a read of the same word, as software would do it
  AST_WRITE_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && cfg_addr == `MAP_OFF_1 ##1 !cfg_wr
    ##1 cfg_rd && !cfg_wr && cfg_addr == `MAP_OFF_1
    |=> cfg_rdata == ($past(cfg_wdata, 3) & `MAP_RW_MASK)) else $error("readback mismatch");
  // mode flag mirrors entry 0 one cycle late, like every other output
  AST_MODE_OUT: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> device_number_compare_enable == $past(cmp_dev)) else $error("mode flag stale");
endmodule : bus_range_node_map
`default_nettype wire

// *** bus_range_map_regs.svh ***
// constants for the bus range node map: offsets, field positions, reset values
// assumes inclusion by bare name from the package and the design modules
// Contract
// - four map registers at offsets e0 through ec
// - each entry maps one range to one node
// - match when base <= number <= limit
// - compare enable selects device number instead
// - node id from bits 6 to 4
// - identical map copy reads same result everywhere
// - limit 31:24, base 23:16, link 9:8, sublink 10
`ifndef BUS_RANGE_MAP_REGS_SVH
`define BUS_RANGE_MAP_REGS_SVH
`define MAP_ENTRIES 4
`define MAP_OFF_0 8'he0
`define MAP_OFF_1 8'he4
`define MAP_OFF_2 8'he8
`define MAP_OFF_3 8'hec
`define MAP_RESET 32'h0000_0000
`define MAP_RW_MASK 32'hffff_0777
`define FLD_LIMIT_HI 31
`define FLD_LIMIT_LO 24
`define FLD_BASE_HI 23
`define FLD_BASE_LO 16
`define FLD_SUBLINK 10
`define FLD_LINK_HI 9
`define FLD_LINK_LO 8
`define FLD_NODE_HI 6
`define FLD_NODE_LO 4
`define FLD_DEV_CMP 2
`define FLD_WE 1
`define FLD_RE 0
`endif

// *** bus_range_map_pkg.sv ***
// types shared by the bus range node map
// assumes the constants header sits in the same folder
`default_nettype none
`include "bus_range_map_regs.svh"
package bus_range_map_pkg;
  typedef logic [7:0] cfg_addr_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0] number_t;
  typedef logic [2:0] node_t;
  typedef logic [1:0] link_t;
endpackage : bus_range_map_pkg
`default_nettype wire

// *** map_reg_store.sv ***
// holds the four map words; read data comes out of a register
// assumes one write or read port driven by the configuration access logic
`timescale 1ns/1ps
`default_nettype none
`include "bus_range_map_regs.svh"
module map_reg_store
  import bus_range_map_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire bus_range_map_pkg::word_t wr_data,
  input wire logic [1:0] rd_idx,
  input wire logic rd_en,
  output bus_range_map_pkg::word_t rd_data,
  output bus_range_map_pkg::word_t entries [`MAP_ENTRIES]
);
  word_t mem_reg [`MAP_ENTRIES];
  word_t mem_next [`MAP_ENTRIES];
  word_t rd_reg;
  word_t rd_next;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // reserved bits are masked on write so they always read zero
  always_comb
  begin
    mem_next = mem_reg;
    if (wr_en)
    begin
      mem_next[wr_idx] = wr_data & `MAP_RW_MASK;
    end
    // no mapped read leaves the read register at zero, so the top needs no output mux
    rd_next = rd_en ? mem_next[rd_idx] : `MAP_RESET;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `MAP_ENTRIES; i++)
      begin
        mem_reg[i] <= `MAP_RESET;
      end
      rd_reg <= `MAP_RESET;
    end
    else
    begin
      mem_reg <= mem_next;
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;
  assign entries = mem_reg;
endmodule : map_reg_store
`default_nettype wire

// *** route_source.sv ***
// far-side model: a configuration cycle source issuing route requests
// assumes the bench drives en and a hint near a range edge
`timescale 1ns/1ps
`default_nettype none
module route_source (
  input wire logic clk,
  input wire logic en,
  input wire logic [7:0] hint,
  output logic route_req,
  output logic route_is_write,
  output logic [7:0] bus_number,
  output logic [4:0] device_number
);
  logic [7:0] n;
  // quiet at time zero
  initial
  begin
    route_req = 1'b0;
    route_is_write = 1'b0;
    bus_number = 8'h00;
    device_number = 5'h00;
  end
  // numbers keep changing while idle, so a stale value never looks meaningful
  always @(posedge clk)
  begin
    #2;
    n = hint + 8'($urandom_range(0, 2)) - 8'h01;
    route_req = en && ($urandom_range(0, 3) != 0);
    route_is_write = 1'($urandom_range(0, 1));
    bus_number = $urandom_range(0, 1) ? n : 8'($urandom);
    device_number = $urandom_range(0, 1) ? n[4:0] : 5'($urandom);
  end
endmodule : route_source
`default_nettype wire

// *** bus_range_node_map_test.sv ***
// self-checking bench for the bus range node map, with a queue-based model
// assumes route_source.sv and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "bus_range_map_regs.svh"
module bus_range_node_map_test;
  import bus_range_map_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, en = 1'b0;
  cfg_addr_t cfg_addr = 8'h00;
  word_t cfg_wdata = 32'h0, w;
  number_t hint = 8'h00;
  logic [31:0] cfg_rdata;
  logic [31:0] mw [4];
  logic [2:0] dest_node_id;
  logic [1:0] dest_link_id;
  logic [6:0] e;
  logic [6:0] exp_q [$];
  logic [4:0] device_number;
  logic [7:0] bus_number, b;
  logic cfg_rvalid, route_valid, route_hit, dest_sublink, device_number_compare_enable;
  logic route_req, route_is_write, v;
  int miscompares = 0, cmp_count = 0, k;

  always #12.5 clk = ~clk;

  bus_range_node_map uut (.clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .route_req, .route_is_write, .bus_number, .device_number,
    .route_valid, .route_hit, .dest_node_id, .dest_link_id, .dest_sublink,
    .device_number_compare_enable);
  route_source src (.clk, .en, .hint, .route_req, .route_is_write, .bus_number,
    .device_number);

  // --------
  // model and checks
  // --------
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic mapped(input cfg_addr_t a);
    return a[7:4] == 4'he && a[1:0] == 2'h0;
  endfunction : mapped

  // walk down so the lowest matching index wins
  function automatic logic [6:0] rexp(input logic wr, input logic [7:0] bn, input logic [4:0] dn);
    logic [7:0] n;
    logic [6:0] r;
    n = mw[0][2] ? {3'h0, dn} : bn;
    r = 7'h00;
    for (int i = 3; i >= 0; i--)
      if (mw[i][wr] && n >= mw[i][23:16] && n <= mw[i][31:24])
        r = {1'b1, mw[i][6:4], mw[i][9:8], mw[i][10]};
    return r;
  endfunction : rexp

  // idle cycle after each access keeps strobes from toggling twice in a step
  task automatic cfg_write(input cfg_addr_t a, input word_t d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clk);
    #2 cfg_wr = 1'b0;
    if (mapped(a))
      mw[a[3:2]] = d & `MAP_RW_MASK;
    @(posedge clk);
    #2;
  endtask : cfg_write

  task automatic cfg_read(input cfg_addr_t a);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge clk);
    #2 cfg_rd = 1'b0;
    chk("cfg_rvalid", 32'(cfg_rvalid), 32'h1);
    chk("cfg_rdata", cfg_rdata, mapped(a) ? mw[a[3:2]] : 32'h0);
    @(posedge clk);
    #2;
    chk("cfg_rvalid", 32'(cfg_rvalid), 32'h0);
  endtask : cfg_read

  // result of the request taken at this edge is settled 1 ns later
  always @(posedge clk)
  begin
    v = route_req && rst_n;
    if (v)
      exp_q.push_back(rexp(route_is_write, bus_number, device_number));
    #1;
    if (rst_n)
      chk("route_valid", 32'(route_valid), 32'(v));
    if (v)
    begin
      e = exp_q.pop_front();
      chk("route", 32'({route_hit, dest_node_id, dest_link_id, dest_sublink}), 32'(e));
      chk("cmp_mode", 32'(device_number_compare_enable), 32'(mw[0][2]));
    end
  end

  // --------
  // stimulus
  // --------
  initial
  begin
    void'($urandom(32'h2ffd));
    for (int i = 0; i < 4; i++)
      mw[i] = `MAP_RESET;
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 7; i++)
      cfg_read(8'hd8 + 8'(i * 4));
    for (int i = 0; i < 7; i++)
    begin
      cfg_write(8'hd8 + 8'(i * 4), 32'hffff_ffff);
      cfg_read(8'hd8 + 8'(i * 4));
    end
    // phase 0 compares bus numbers, phase 1 device numbers
    for (int ph = 0; ph < 2; ph++)
      repeat (4)
      begin
        for (int i = 0; i < 4; i++)
        begin
          b = ph ? 8'($urandom_range(0, 24)) : 8'($urandom_range(0, 220));
          w = {b + 8'($urandom_range(0, ph ? 7 : 35)), b, 16'($urandom)};
          if (i == 0)
            w[2] = 1'(ph);
          cfg_write(8'he0 + 8'(i * 4), w);
          cfg_read(8'he0 + 8'(i * 4));
        end
        en = 1'b1;
        repeat (60)
        begin
          k = $urandom_range(0, 3);
          hint = $urandom_range(0, 1) ? mw[k][31:24] : mw[k][23:16];
          @(posedge clk);
        end
        en = 1'b0;
        repeat (2) @(posedge clk);
        #2;
      end
    report_and_stop();
  end

  // cut a hang short well beyond the expected run of about 670 cycles
  initial
  begin
    #(25 * 5000);
    miscompares++;
    report_and_stop();
  end
endmodule : bus_range_node_map_test
`default_nettype wire
